// File: design/ssp_pkg.sv
/*
  Package for the serial port: register offsets, field positions, reset values
  and shared enumerations. Assumes a 32-bit AHB-Lite bus with word registers.
*/
package ssp_pkg;
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_RATE   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DATA   = 8'h10;

  // Control 1 fields
  localparam int C1_RF_IE   = 7;
  localparam int C1_ON      = 6;
  localparam int C1_TE_IE   = 5;
  localparam int C1_MASTER  = 4;
  localparam int C1_IDLE    = 3;
  localparam int C1_PHASE   = 2;
  localparam int C1_SEL_OE  = 1;
  localparam int C1_LSB     = 0;
  // Control 2 fields
  localparam int C2_FAULT_EN = 4;
  localparam int C2_DRIVE_EN = 3;
  localparam int C2_SINGLE   = 0;
  localparam logic [7:0] C2_MASK = 8'h19;
  // Rate fields
  localparam int RT_PRE_LO  = 4;
  localparam int RT_SEL_LO  = 0;
  // Status fields
  localparam int ST_RXFULL  = 7;
  localparam int ST_FAULT   = 4;
  localparam int ST_TXEMPTY = 5;

  localparam logic [7:0] CTRL1_RST  = 8'h04;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;
  localparam logic [3:0] BIT_LAST   = 4'hF;
  localparam logic [9:0] RATE_ONE   = 10'h001;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } ssp_state_type;
endpackage

// File: design/ssp_rate_if.sv
/*
  Carrier between the port core and its bit-rate divider.
  Assumes both ends run on the bus clock.
*/
`timescale 1ns/100ps
interface ssp_rate_if;
  logic       run;
  logic [2:0] prescale_field;
  logic [2:0] rate_select_field;
  logic       tick;
  modport core (output run, output prescale_field, output rate_select_field, input tick);
  modport div  (input run, input prescale_field, input rate_select_field, output tick);
endinterface

// File: design/ssp_rate_div.sv
/*
  Two-stage bit-rate divider. A tick marks each half bit time of the master clock.
  Assumes run is held high for the whole transfer and dropped between transfers.
*/
`timescale 1ns/100ps
module ssp_rate_div
  import ssp_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  ssp_rate_if.div   rate
);
  typedef struct packed {
    logic [2:0] pre;
    logic [8:0] cnt;
  } ssp_div_type;

  ssp_div_type s_q;
  ssp_div_type s_d;
  logic [8:0]  half_lim;

  // Half of 2^(n+1) is 2^n, so one tick per half bit
  assign half_lim = 9'((RATE_ONE << rate.rate_select_field) - RATE_ONE);

  always_comb begin
    s_d = s_q;
    if (!rate.run) begin
      s_d.pre = '0;
      s_d.cnt = '0;
    end else if (s_q.pre == rate.prescale_field) begin
      s_d.pre = '0;
      if (s_q.cnt == half_lim) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = 9'(s_q.cnt + 9'h001);
      end
    end else begin
      s_d.pre = 3'(s_q.pre + 3'h1);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Combinational so the first half bit of a frame is as long as the rest
  assign rate.tick = rate.run && (s_q.pre == rate.prescale_field) && (s_q.cnt == half_lim);
endmodule

// File: design/ssp_top.sv
/*
  Byte-wide synchronous serial port, master or slave, with AHB-Lite registers,
  double-buffered data, two-stage divider and single-wire option.
  Assumes pins arrive asynchronously; port logic owns any pin whose enable is low.
*/
`timescale 1ns/100ps
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        sel_n_in,
  output logic             sel_n_out,
  output logic             sel_oe_out,
  output logic             irq_out
);
  import ssp_pkg::*;

  typedef struct packed {
    logic                 wr_pend;
    logic                 rd_pend;
    logic [7:0]           addr;
    logic [31:0]          rdata;
    logic [7:0]           ctrl1;
    logic [7:0]           ctrl2;
    logic [7:0]           rate;
    logic [7:0]           tx_buf;
    logic                 tx_empty;
    logic [7:0]           rx_buf;
    logic                 rx_full;
    logic                 fault;
    logic                 st_read;
    ssp_state_type        state;
    logic [7:0]           shreg;
    logic [3:0]           half;
    logic                 sck;
    logic                 in_bit;
    logic [2:0]           sck_s;
    logic [2:0]           sel_s;
    logic [2:0]           mosi_s;
    logic [2:0]           miso_s;
    logic                 sck_fq;
    logic                 sel_fq;
  } ssp_core_type;

  ssp_core_type s_q;
  ssp_core_type s_d;
  ssp_rate_if   rate_bus ();

  logic on;
  logic master;
  logic single;
  logic lsb;
  logic phase;
  logic idle_lvl;
  logic sck_f;
  logic sel_f;
  logic din_f;
  logic sck_prev;
  logic addr_ok;
  logic take;
  logic [7:0] st_val;
  logic [7:0] rd_byte;
  logic lead_edge;
  logic trail_edge;
  logic sample_now;
  logic shift_now;
  logic slave_act;
  logic fault_in;

  assign on       = s_q.ctrl1[C1_ON];
  assign master   = s_q.ctrl1[C1_MASTER];
  assign single   = s_q.ctrl2[C2_SINGLE];
  assign lsb      = s_q.ctrl1[C1_LSB];
  assign phase    = s_q.ctrl1[C1_PHASE];
  assign idle_lvl = s_q.ctrl1[C1_IDLE];

  // A pin change counts once the second and third stages agree
  // Disagreeing stages keep the last accepted level, so a glitch is not an edge
  assign sck_f = (s_q.sck_s[1] == s_q.sck_s[2]) ? s_q.sck_s[2] : s_q.sck_fq;
  assign sel_f = (s_q.sel_s[1] == s_q.sel_s[2]) ? s_q.sel_s[2] : s_q.sel_fq;
  assign sck_prev = s_q.sck_fq;
  // Shifter input routing by role and single-wire choice
  always_comb begin
    if (master) begin
      din_f = single ? s_q.mosi_s[2] : s_q.miso_s[2];
    end else begin
      din_f = single ? s_q.miso_s[2] : s_q.mosi_s[2];
    end
  end

  assign slave_act = on && !master && !sel_f;
  assign fault_in  = on && master && s_q.ctrl2[C2_FAULT_EN] && !s_q.ctrl1[C1_SEL_OE] && !sel_f;

  assign addr_ok = (s_q.addr == OFS_CTRL1) || (s_q.addr == OFS_CTRL2) || (s_q.addr == OFS_RATE) ||
                   (s_q.addr == OFS_STATUS) || (s_q.addr == OFS_DATA);
  assign take    = hsel_in && hready_in && htrans_in[1];

  always_comb begin
    st_val             = 8'h00;
    st_val[ST_RXFULL]  = s_q.rx_full;
    st_val[ST_TXEMPTY] = s_q.tx_empty;
    st_val[ST_FAULT]   = s_q.fault;
  end

  always_comb begin
    case (haddr_in[7:0])
      OFS_CTRL1:  rd_byte = s_q.ctrl1;
      OFS_CTRL2:  rd_byte = s_q.ctrl2;
      OFS_RATE:   rd_byte = s_q.rate;
      OFS_STATUS: rd_byte = st_val;
      OFS_DATA:   rd_byte = s_q.rx_buf;
      default:    rd_byte = 8'h00;
    endcase
  end

  // Serial clock edges seen by the slave, after polarity
  assign lead_edge  = slave_act && (sck_f != sck_prev) && ((sck_f ^ idle_lvl) == 1'b1);
  assign trail_edge = slave_act && (sck_f != sck_prev) && ((sck_f ^ idle_lvl) == 1'b0);

  // Each half bit either samples or shifts; phase swaps which edge does which
  always_comb begin
    if (master) begin
      sample_now = rate_bus.tick && (s_q.half[0] == 1'b0) && (s_q.state == ST_SHIFT);
      shift_now  = rate_bus.tick && (s_q.half[0] == 1'b1) && (s_q.state == ST_SHIFT);
    end else begin
      sample_now = phase ? trail_edge : lead_edge;
      shift_now  = phase ? lead_edge : trail_edge;
    end
  end

  assign rate_bus.run               = on && master && (s_q.state == ST_SHIFT);
  assign rate_bus.prescale_field    = s_q.rate[RT_PRE_LO +: 3];
  assign rate_bus.rate_select_field = s_q.rate[RT_SEL_LO +: 3];

  always_comb begin
    s_d        = s_q;
    s_d.sck_s  = {s_q.sck_s[1:0], sck_in};
    s_d.sel_s  = {s_q.sel_s[1:0], sel_n_in};
    s_d.mosi_s = {s_q.mosi_s[1:0], mosi_in};
    s_d.miso_s = {s_q.miso_s[1:0], miso_in};
    s_d.sck_fq = sck_f;
    s_d.sel_fq = sel_f;
    s_d.wr_pend = 1'b0;
    s_d.rd_pend = 1'b0;
    if (take) begin
      s_d.addr    = haddr_in[7:0];
      s_d.wr_pend = hwrite_in;
      s_d.rd_pend = !hwrite_in;
      s_d.rdata   = {24'h000000, rd_byte};
      if (!hwrite_in && haddr_in[7:0] == OFS_STATUS) begin
        s_d.st_read = 1'b1;
      end
      if (!hwrite_in && haddr_in[7:0] == OFS_DATA && s_q.st_read) begin
        s_d.rx_full = 1'b0;
        s_d.fault   = 1'b0;
        s_d.st_read = 1'b0;
      end
    end
    if (s_q.wr_pend) begin
      case (s_q.addr)
        OFS_CTRL1: s_d.ctrl1 = hwdata_in[7:0];
        OFS_CTRL2: s_d.ctrl2 = hwdata_in[7:0] & C2_MASK;
        OFS_RATE:  s_d.rate  = hwdata_in[7:0] & 8'h77;
        OFS_DATA: begin
          s_d.tx_buf   = hwdata_in[7:0];
          s_d.tx_empty = 1'b0;
        end
        default: s_d.tx_buf = s_d.tx_buf;
      endcase
    end

    case (s_q.state)
      ST_IDLE: begin
        s_d.sck  = idle_lvl;
        s_d.half = 4'h0;
        if (on && master && !s_q.tx_empty && !fault_in) begin
          s_d.shreg    = s_q.tx_buf;
          // A byte written in this very cycle stays queued
          s_d.tx_empty = !(s_q.wr_pend && (s_q.addr == OFS_DATA));
          s_d.state    = ST_SHIFT;
          if (phase) begin
            s_d.sck = !idle_lvl;
          end
        end else if (slave_act) begin
          s_d.shreg    = s_q.tx_empty ? s_q.shreg : s_q.tx_buf;
          s_d.tx_empty = !(s_q.wr_pend && (s_q.addr == OFS_DATA));
          s_d.state    = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sample_now) begin
          s_d.in_bit = din_f;
        end
        if (master && rate_bus.tick) begin
          s_d.half = 4'(s_q.half + 4'h1);
          // Toggle on every half bit except the last one when phase is one
          if (!(s_q.half == BIT_LAST)) begin
            s_d.sck = !s_q.sck;
          end else begin
            s_d.sck = idle_lvl;
          end
          if (!phase && s_q.half == BIT_LAST) begin
            s_d.sck = idle_lvl;
          end
        end
        if (shift_now) begin
          s_d.half = master ? s_d.half : 4'(s_q.half + 4'h2);
          s_d.shreg = lsb ? {s_q.in_bit, s_q.shreg[7:1]} : {s_q.shreg[6:0], s_q.in_bit};
          if (s_q.half == BIT_LAST || (!master && s_q.half == 4'hE)) begin
            s_d.state = ST_DONE;
          end
        end
        if (!master && sel_f) begin
          s_d.state = ST_IDLE;
        end
      end
      ST_DONE: begin
        s_d.rx_buf  = s_q.shreg;
        s_d.rx_full = 1'b1;
        s_d.state   = ST_IDLE;
        s_d.sck     = idle_lvl;
      end
      default: s_d.state = ST_IDLE;
    endcase

    if (fault_in) begin
      s_d.fault = 1'b1;
      s_d.ctrl1[C1_MASTER] = 1'b0;
      s_d.state = ST_IDLE;
    end

    if (!on) begin
      s_d.state    = ST_IDLE;
      s_d.tx_empty = 1'b1;
      s_d.rx_full  = 1'b0;
      s_d.half     = 4'h0;
      s_d.sck      = idle_lvl;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q          <= '0;
      s_q.ctrl1    <= CTRL1_RST;
      s_q.ctrl2    <= CTRL2_RST;
      s_q.rate     <= RATE_RST;
      s_q.tx_empty <= 1'b1;
      s_q.state    <= ST_IDLE;
      s_q.sck_s    <= 3'b111;
      s_q.sel_s    <= 3'b111;
      s_q.sck_fq   <= 1'b1;
      s_q.sel_fq   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ssp_rate_div u_div (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .rate        (rate_bus)
  );

  // Pin routing; a low enable hands the pin back to port logic
  always_comb begin
    sck_oe_out  = on && master;
    mosi_oe_out = 1'b0;
    miso_oe_out = 1'b0;
    sel_oe_out  = 1'b0;
    if (on) begin
      if (!single) begin
        mosi_oe_out = master;
        miso_oe_out = !master && !sel_f;
      end else if (master) begin
        mosi_oe_out = s_q.ctrl2[C2_DRIVE_EN];
      end else begin
        miso_oe_out = s_q.ctrl2[C2_DRIVE_EN] && !sel_f;
      end
      sel_oe_out = master && s_q.ctrl2[C2_FAULT_EN] && s_q.ctrl1[C1_SEL_OE];
    end
  end

  assign sck_out       = s_q.sck;
  assign mosi_out      = lsb ? s_q.shreg[0] : s_q.shreg[7];
  assign miso_out      = lsb ? s_q.shreg[0] : s_q.shreg[7];
  assign sel_n_out     = (s_q.state == ST_IDLE);
  assign hrdata_out    = s_q.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign irq_out       = (s_q.ctrl1[C1_RF_IE] && (s_q.rx_full || s_q.fault)) ||
                         (s_q.ctrl1[C1_TE_IE] && s_q.tx_empty);
endmodule

// File: tb/ssp_slave_model.sv
/*
  Remote serial slave standing at the far side of the port.
  Assumes the master frames each byte with a low select.
*/
`timescale 1ns/100ps
module ssp_slave_model (
  input  wire logic       sck_in,
  input  wire logic       sel_n_in,
  input  wire logic       mosi_in,
  input  wire logic       idle_in,
  input  wire logic       phase_in,
  input  wire logic       lsb_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  logic [7:0] sh;
  initial miso_out = 1'b0;
  initial rx_out = 8'h00;
  always @(negedge sel_n_in) begin
    sh = tx_in;
    if (!phase_in)
      miso_out = lsb_in ? sh[0] : sh[7];
  end
  always @(posedge sel_n_in) begin
    rx_out = sh;
    // Released line must not keep a stale bit
    miso_out = ~miso_out;
  end
  always @(sck_in) begin
    if (!sel_n_in) begin
      if ((sck_in != idle_in) ^ phase_in)
        sh = lsb_in ? {mosi_in, sh[7:1]} : {sh[6:0], mosi_in};
      else
        miso_out = lsb_in ? sh[0] : sh[7];
    end
  end
endmodule

// File: tb/ssp_top_sva.sv
/*
  Pin assertions for the serial port, shadowing control writes seen on the bus.
  Assumes no mode fault is raised while it watches.
*/
`timescale 1ns/100ps
module ssp_top_sva
  import ssp_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        sck_out,
  input wire logic        sck_oe_out,
  input wire logic        mosi_oe_out,
  input wire logic        miso_oe_out,
  input wire logic        sel_n_out,
  input wire logic        sel_oe_out
);
  logic [7:0]  c1_q, c2_q, rt_q, ad_q;
  logic        wr_q, sck_q, mid_q, on, mst, chg;
  logic [15:0] gap_q, half;
  assign on = c1_q[C1_ON];
  assign mst = c1_q[C1_MASTER];
  assign chg = sck_out != sck_q;
  assign half = {12'h000, {1'b0, rt_q[6:4]} + 4'h1} << rt_q[2:0];
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      c1_q <= CTRL1_RST;
      c2_q <= CTRL2_RST;
      rt_q <= RATE_RST;
      ad_q <= 8'h00;
      wr_q <= 1'b0;
      sck_q <= 1'b0;
      mid_q <= 1'b0;
      gap_q <= 16'h0000;
    end else begin
      wr_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
      ad_q <= haddr_in[7:0];
      sck_q <= sck_out;
      gap_q <= chg ? 16'h0001 : gap_q + 16'h0001;
      // Only gaps between two edges of one frame are timed
      mid_q <= sel_n_out ? 1'b0 : (chg | mid_q);
      if (wr_q && ad_q == OFS_CTRL1)
        c1_q <= hwdata_in[7:0];
      if (wr_q && ad_q == OFS_CTRL2)
        c2_q <= hwdata_in[7:0] & C2_MASK;
      if (wr_q && ad_q == OFS_RATE)
        rt_q <= hwdata_in[7:0];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_off_release: assert property (!on |-> !(sck_oe_out | mosi_oe_out | miso_oe_out | sel_oe_out))
    else $error("pin driven while port off");
  a_master_clock: assert property (on && mst |-> sck_oe_out)
    else $error("master not driving clock");
  a_slave_clock: assert property (on && !mst |-> !sck_oe_out)
    else $error("slave driving clock");
  a_dir_normal: assert property (on && mst && !c2_q[C2_SINGLE] |-> mosi_oe_out && !miso_oe_out)
    else $error("master data directions wrong");
  a_single_wire: assert property (on && mst && c2_q[C2_SINGLE] |->
    mosi_oe_out == c2_q[C2_DRIVE_EN] && !miso_oe_out)
    else $error("single wire drive wrong");
  a_sel_port: assert property (on && mst && !c2_q[C2_FAULT_EN] |-> !sel_oe_out)
    else $error("select pin not released");
  a_clock_idle: assert property (on && mst && sel_n_out && $past(sel_n_out, 2) &&
    $past(c1_q, 2) == c1_q |-> sck_out == c1_q[C1_IDLE])
    else $error("clock not at idle level");
  a_bit_rate: assert property (chg && mid_q && !sel_n_out |-> gap_q == half)
    else $error("half bit time wrong");
endmodule

bind ssp_top ssp_top_sva chk_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out),
  .miso_oe_out(miso_oe_out), .sel_n_out(sel_n_out), .sel_oe_out(sel_oe_out));

// File: tb/ssp_top_bench.sv
/*
  Self-checking bench for the serial port: bus tasks, scenarios, remote slave.
  Assumes one 25 MHz clock and the port as sole AHB-Lite slave.
*/
`timescale 1ns/100ps
module ssp_top_bench;
  import ssp_pkg::*;
  logic        core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        m_sck = 1'b0, m_mosi = 1'b0, m_sel_n = 1'b1;
  logic        md_idle = 1'b0, md_phase = 1'b0, md_lsb = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [7:0]  md_tx = 8'h00;
  wire  [31:0] hrdata;
  wire  [7:0]  md_rx;
  wire         hrdy, hresp, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_n_o, sel_oe, irq, miso_m;
  wire         sck_w = sck_oe ? sck_o : m_sck;
  wire         mosi_w = mosi_oe ? mosi_o : m_mosi;
  wire         miso_w = miso_oe ? miso_o : miso_m;
  wire         sel_n_w = sel_oe ? sel_n_o : m_sel_n;
  int          mismatches = 0, comparisons = 0;
  ssp_top dut_u (.core_clk_in(core_clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(miso_w), .miso_out(miso_o),
    .miso_oe_out(miso_oe), .sel_n_in(sel_n_w), .sel_n_out(sel_n_o), .sel_oe_out(sel_oe), .irq_out(irq));
  ssp_slave_model far_u (.sck_in(sck_w), .sel_n_in(sel_n_w), .mosi_in(mosi_w), .idle_in(md_idle),
    .phase_in(md_phase), .lsb_in(md_lsb), .tx_in(md_tx), .miso_out(miso_m), .rx_out(md_rx));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    n = 0;
    do @(posedge core_clk); while (hrdy !== 1'b1 && ++n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hrdy !== 1'b1 && ++n < 200);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic wrd(input string nm, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    logic [31:0] r;
    wr(a, d);
    rd(a, r);
    chk(nm, e, r);
  endtask
  // Polls for a received byte, then reads it; the status read arms the flag clear
  task automatic wait_rx(output logic [31:0] r);
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS, r);
      if (r[ST_RXFULL]) break;
    end
    chk("rx full", 32'h1, {31'h0, r[ST_RXFULL]});
    rd(OFS_DATA, r);
  endtask
  task automatic wait_sel;
    for (int i = 0; i < 200 && sel_n_w !== 1'b1; i++) @(posedge core_clk);
  endtask
  task automatic pulse;
    m_sck <= 1'b1;
    wt(16);
    m_sck <= 1'b0;
    wt(16);
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic [7:0]  rv [4];
    rv = '{8'h04, 8'h00, 8'h00, 8'h20};
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), r);
      chk("reset value", {24'h0, rv[i]}, r);
    end
    wrd("ctrl2", OFS_CTRL2, 32'hFF, 32'h19);
    wrd("rate", OFS_RATE, 32'hFF, 32'h77);
    wrd("unmapped", 8'h14, 32'hFF, 32'h0);
    chk("resp", 32'h0, {31'h0, hresp});
    wr(OFS_CTRL2, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_pins;
    logic [7:0] v [3];
    v = '{8'h00, 8'h01, 8'h09};
    wr(OFS_CTRL1, 32'h50);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL2, {24'h0, v[i]});
      wt(1);
      chk("mosi oe", {31'h0, v[i] != 8'h01}, {31'h0, mosi_oe});
      chk("miso oe", 32'h0, {31'h0, miso_oe});
    end
    wr(OFS_CTRL1, 32'h40);
    wt(1);
    chk("slave pins", 32'h0, {30'h0, mosi_oe, sck_oe});
    $display("pins test done");
  endtask
  task automatic t_master;
    logic [31:0] r;
    for (int m = 0; m < 4; m++) begin
      md_idle = m[1];
      md_phase = m[0];
      md_lsb = m[0];
      md_tx = 8'h96 + 8'(m);
      wr(OFS_CTRL2, 32'h10);
      // Half bit of at least four clocks covers the pin synchroniser
      wr(OFS_RATE, 32'(m * 16 + 2));
      wr(OFS_CTRL1, {24'h0, 4'h5, m[1], m[0], 1'b1, m[0]});
      wr(OFS_DATA, 32'h3C + 32'(m));
      wait_rx(r);
      chk("master rx", {24'h0, md_tx}, r);
      wait_sel;
      chk("remote rx", 32'h3C + 32'(m), {24'h0, md_rx});
    end
    wr(OFS_DATA, 32'h81);
    wr(OFS_DATA, 32'h42);
    wait_rx(r);
    chk("queued first", {24'h0, md_tx}, r);
    wait_rx(r);
    wait_sel;
    chk("queued last", 32'h42, {24'h0, md_rx});
    $display("master test done");
  endtask
  task automatic t_abort;
    logic [31:0] r;
    wr(OFS_RATE, 32'h77);
    wr(OFS_DATA, 32'h5A);
    wr(OFS_DATA, 32'hA5);
    wt(300);
    wr(OFS_CTRL1, 32'h12);
    wt(1);
    chk("off pins", 32'h0, {28'h0, sck_oe, mosi_oe, miso_oe, sel_oe});
    rd(OFS_STATUS, r);
    chk("flushed", 32'h20, r);
    wr(OFS_CTRL1, 32'h52);
    wt(100);
    rd(OFS_STATUS, r);
    chk("no restart", 32'h20, r);
    chk("no select", 32'h1, {31'h0, sel_n_w});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_CTRL1, 32'h72);
    wt(1);
    chk("irq tx empty", 32'h1, {31'h0, irq});
    $display("abort test done");
  endtask
  task automatic t_slave;
    logic [31:0] r;
    logic [7:0]  got, tx;
    tx = 8'h3C;
    wr(OFS_CTRL2, 32'h0);
    wr(OFS_CTRL1, 32'h40);
    wr(OFS_DATA, 32'hC3);
    // Clocks while unselected must not move the shifter
    repeat (3) pulse;
    m_sel_n <= 1'b0;
    wt(16);
    for (int b = 7; b >= 0; b--) begin
      m_mosi <= tx[b];
      wt(16);
      got[b] = miso_w;
      pulse;
    end
    m_sel_n <= 1'b1;
    wt(16);
    wait_rx(r);
    chk("slave rx", 32'h3C, r);
    chk("slave tx", 32'hC3, {24'h0, got});
    $display("slave test done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_pins;
    t_master;
    t_abort;
    t_slave;
    test_done;
  end
  initial begin
    #(40 * 60000);
    mismatches++;
    test_done;
  end
endmodule
